// [include/als_params.svh]
// Register map, field positions, reset values and timing counts of the light readout
`ifndef ALS_PARAMS_SVH
`define ALS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define REG_STATUS        8'h00
`define REG_MAIN_CFG      8'h01
`define REG_RX_SETUP      8'h02
`define REG_RES_HIGH      8'h04
`define REG_RES_LOW       8'h05
`define REG_UP_HIGH       8'h06
`define REG_UP_LOW        8'h07
`define REG_LOW_HIGH      8'h08
`define REG_LOW_LOW       8'h09
`define REG_PERSIST       8'h0a

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define STAT_IRQ_BIT      0
`define STAT_PWR_BIT      2
`define CFG_IRQ_EN_BIT    0
`define CFG_MODE_LSB      2
`define CFG_TRIM_BIT      5
`define RX_GAIN_LSB       0
`define RX_TIME_LSB       2
`define RES_OVF_BIT       6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MAIN_CFG_RST      8'h24
`define RX_SETUP_RST      4'h0
`define LIMIT_RST         8'h00
`define PERSIST_RST       2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define INTEG_TIME_US     100000
`define CONV_PERIOD_NS    80
`define INTEG_CYC_DEF     (`INTEG_TIME_US * 1000 / `CONV_PERIOD_NS)
`define SAR_SETTLE_CYC    4

`endif

// [include/als_pkg.sv]
// Types shared by the ambient light readout logic
package als_pkg;

  // Operating modes held in the main configuration register
  typedef enum logic [1:0] {
    shutdown_mode             = 2'b00,
    green_minus_infrared_mode = 2'b01,
    green_only_mode           = 2'b10,
    infrared_only_mode        = 2'b11
  } mode_t;

  // Conversion sequencer, Gray along idle, integrate, convert, done
  typedef enum logic [1:0] {
    CV_IDLE  = 2'b00,
    CV_INTEG = 2'b01,
    CV_SAR   = 2'b11,
    CV_DONE  = 2'b10
  } conv_state_t;

  // Serial slave states
  typedef enum logic [2:0] {
    SI_IDLE = 3'b000,
    SI_RX   = 3'b001,
    SI_ACK  = 3'b011,
    SI_TX   = 3'b010,
    SI_RACK = 3'b110
  } ser_state_t;

  // What the byte being received means
  typedef enum logic [1:0] {
    BK_ADDR = 2'b00,
    BK_PTR  = 2'b01,
    BK_DATA = 2'b11
  } byte_kind_t;

endpackage

// [core/ambient_light_readout_control.sv]
// Ambient light readout: serial registers, conversion sequencer, window interrupt
`timescale 1ns/100ps
`include "als_params.svh"

module ambient_light_readout_control import als_pkg::*; #(
  parameter int unsigned INTEG_CYC  = `INTEG_CYC_DEF,
  parameter int unsigned SAR_SETTLE = `SAR_SETTLE_CYC,
  parameter logic [6:0]  DEV_ADDR   = 7'h40   // Arbitrary bus address
) (
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Serial register port, open drain data
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  output logic             int_n,
  // Conversion clock domain and analog front end
  input  wire logic        conv_clk,
  input  wire logic        comp_in,
  output logic [13:0]      dac_code,
  output logic             chan_ir,
  output logic             analog_on,
  output logic [1:0]       light_gain_sel,
  output logic             trim_factory
);

  localparam int unsigned CW = $clog2(INTEG_CYC + 1);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (INTEG_CYC < 64) begin : g_bad_integ
    $error("INTEG_CYC must be at least 64");
  end
  if (SAR_SETTLE < 3 || SAR_SETTLE > 15) begin : g_bad_settle
    $error("SAR_SETTLE must be 3..15");
  end

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic [3:0] res_bits(input logic [1:0] t);
    res_bits = 4'(14 - 2 * int'(t));
  endfunction

  function automatic logic [13:0] full_code(input logic [1:0] t);
    full_code = 14'((32'h1 << res_bits(t)) - 1);
  endfunction

  function automatic logic [CW-1:0] integ_len(input logic [1:0] t);
    integ_len = CW'(INTEG_CYC >> (2 * int'(t)));
  endfunction

  function automatic logic [4:0] persist_need(input logic [1:0] s);
    case (s)
      2'b00:   persist_need = 5'h01;
      2'b01:   persist_need = 5'h02;
      2'b10:   persist_need = 5'h04;
      default: persist_need = 5'h10;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic        irq_flag_q, pwr_flag_q, irq_en_q, trim_q, int_n_q;
  mode_t       mode_q;
  logic [3:0]  rx_setup_q;
  logic [7:0]  up_hi_q, up_lo_q, lo_hi_q, lo_lo_q;
  logic [1:0]  persist_q;
  logic [13:0] res_vis_q, pend_q;
  logic        ovf_vis_q, pend_ovf_q, pend_v_q;
  logic [4:0]  per_cnt_q;
  // Conversion domain
  logic        crst_meta_q, crst_n_q, comp_meta_q, comp_q;
  logic [3:0]  cfg_meta_q, cfg_sync_q, cfg_prev_q;
  // A config word is taken only once two samples agree, so bit skew cannot mix codes
  wire         cfg_ok = (cfg_sync_q == cfg_prev_q);
  conv_state_t cst_q;
  logic [CW-1:0] cnt_q;
  mode_t       cm_q;
  logic [1:0]  ct_q;
  logic        second_q, chan_ir_q, analog_on_q, done_tog_q, res_ovf_w_q;
  logic [3:0]  bit_q, set_q;
  logic [13:0] dac_q, green_q, res_w_q;
  // Serial slave
  logic        scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic        tog_m_q, tog_s_q, tog_p_q;
  ser_state_t  sst_q;
  byte_kind_t  kind_q;
  logic [3:0]  bcnt_q;
  logic [7:0]  sh_q, tx_q, ptr_q, rd_byte;
  logic        rw_q, oe_n_q, sda_out_q, freeze_q;

  // ----------------------------------------------------------------------
  // Conversion domain: reset, configuration and comparator synchronisers
  // ----------------------------------------------------------------------
  // Mode and time cross as one word; a third stage lets the sequencer wait
  // until the word has settled before it starts a conversion.
  always_ff @(posedge conv_clk) begin
    crst_meta_q <= resetn;
    crst_n_q    <= crst_meta_q;
    cfg_meta_q  <= {mode_q, rx_setup_q[`RX_TIME_LSB +: 2]};
    cfg_sync_q  <= cfg_meta_q;
    cfg_prev_q  <= cfg_sync_q;
    comp_meta_q <= comp_in;
    comp_q      <= comp_meta_q;
  end

  // Front end power follows the mode, nothing else is touched
  always_ff @(posedge conv_clk) begin
    if (!crst_n_q) analog_on_q <= 1'b0;
    else analog_on_q <= (cfg_sync_q[3:2] != shutdown_mode);
  end

  // Integrate, then successive approximation, one or two channels per result
  always_ff @(posedge conv_clk) begin
    if (!crst_n_q) begin
      cst_q       <= CV_IDLE;
      cnt_q       <= '0;
      cm_q        <= shutdown_mode;
      ct_q        <= 2'b00;
      second_q    <= 1'b0;
      chan_ir_q   <= 1'b0;
      bit_q       <= 4'h0;
      set_q       <= 4'h0;
      dac_q       <= 14'h0000;
      green_q     <= 14'h0000;
      res_w_q     <= 14'h0000;
      res_ovf_w_q <= 1'b0;
      done_tog_q  <= 1'b0;
    end else begin
      unique case (cst_q)
        CV_IDLE: if (cfg_ok && cfg_sync_q[3:2] != shutdown_mode) begin
          cm_q      <= mode_t'(cfg_sync_q[3:2]);
          ct_q      <= cfg_sync_q[1:0];
          second_q  <= 1'b0;
          chan_ir_q <= (cfg_sync_q[3:2] == infrared_only_mode);
          cnt_q     <= integ_len(cfg_sync_q[1:0]);
          cst_q     <= CV_INTEG;
        end
        CV_INTEG: begin
          cnt_q <= cnt_q - CW'(1);
          if (cfg_sync_q[3:2] == shutdown_mode) begin
            cst_q <= CV_IDLE;
          end else if (cnt_q <= CW'(1)) begin
            bit_q <= res_bits(ct_q) - 4'h1;
            dac_q <= 14'(32'h1 << (res_bits(ct_q) - 4'h1));
            set_q <= 4'h0;
            cst_q <= CV_SAR;
          end
        end
        CV_SAR: begin
          set_q <= set_q + 4'h1;
          if (set_q == 4'(SAR_SETTLE - 1)) begin
            set_q <= 4'h0;
            // Comparator high keeps the trial bit, then try the next lower one
            if (!comp_q) dac_q[bit_q] <= 1'b0;
            if (bit_q == 4'h0) cst_q <= CV_DONE;
            else begin
              bit_q              <= bit_q - 4'h1;
              dac_q[bit_q - 4'h1] <= 1'b1;
            end
          end
        end
        CV_DONE: begin
          if (cm_q == green_minus_infrared_mode && !second_q) begin
            green_q   <= dac_q;
            second_q  <= 1'b1;
            chan_ir_q <= 1'b1;
            cnt_q     <= integ_len(ct_q);
            cst_q     <= CV_INTEG;
          end else begin
            // Difference clamps at zero; saturation of the sensed channel is overflow
            if (cm_q == green_minus_infrared_mode) begin
              res_w_q     <= (green_q >= dac_q) ? green_q - dac_q : 14'h0000;
              res_ovf_w_q <= (green_q == full_code(ct_q)) || (dac_q == full_code(ct_q));
            end else begin
              res_w_q     <= dac_q;
              res_ovf_w_q <= (dac_q == full_code(ct_q));
            end
            done_tog_q <= ~done_tog_q;
            chan_ir_q  <= 1'b0;
            cst_q      <= CV_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // System domain: pin and completion synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    scl_m_q <= scl_in;
    scl_s_q <= scl_m_q;
    scl_p_q <= scl_s_q;
    sda_m_q <= sda_in;
    sda_s_q <= sda_m_q;
    sda_p_q <= sda_s_q;
    tog_m_q <= done_tog_q;
    tog_s_q <= tog_m_q;
    tog_p_q <= tog_s_q;
  end

  // The result word changes on the same edge as its toggle, then holds for milliseconds
  wire done_p   = tog_s_q ^ tog_p_q;
  wire start_c  = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_c   = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire wr_stb   = (sst_q == SI_RX) & scl_fall & (bcnt_q == 4'h8) & (kind_q == BK_DATA);
  wire rd_stb   = (sst_q == SI_ACK) & scl_fall & rw_q;
  wire stat_rd  = rd_stb & (ptr_q == `REG_STATUS);

  // ----------------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sst_q    <= SI_IDLE;
      kind_q   <= BK_ADDR;
      bcnt_q   <= 4'h0;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      ptr_q    <= 8'h00;
      rw_q     <= 1'b0;
      oe_n_q   <= 1'b1;
      freeze_q <= 1'b0;
    end else if (start_c) begin
      sst_q  <= SI_RX;
      kind_q <= BK_ADDR;
      bcnt_q <= 4'h0;
      oe_n_q <= 1'b1;
    end else if (stop_c) begin
      sst_q    <= SI_IDLE;
      oe_n_q   <= 1'b1;
      freeze_q <= 1'b0;
    end else begin
      unique case (sst_q)
        SI_IDLE: ;
        SI_RX: if (scl_rise) begin
          sh_q   <= {sh_q[6:0], sda_s_q};
          bcnt_q <= bcnt_q + 4'h1;
        end else if (scl_fall && bcnt_q == 4'h8) begin
          bcnt_q <= 4'h0;
          unique case (kind_q)
            BK_ADDR: if (sh_q[7:1] == DEV_ADDR) begin
              rw_q   <= sh_q[0];
              oe_n_q <= 1'b0;
              sst_q  <= SI_ACK;
              if (sh_q[0]) freeze_q <= 1'b1;
            end else sst_q <= SI_IDLE;
            BK_PTR: begin
              ptr_q  <= sh_q;
              oe_n_q <= 1'b0;
              sst_q  <= SI_ACK;
            end
            BK_DATA: begin
              ptr_q  <= ptr_q + 8'h01;
              oe_n_q <= 1'b0;
              sst_q  <= SI_ACK;
            end
          endcase
        end
        SI_ACK: if (scl_fall) begin
          bcnt_q <= 4'h0;
          if (rw_q) begin
            tx_q   <= rd_byte;
            ptr_q  <= ptr_q + 8'h01;
            oe_n_q <= rd_byte[7];
            sst_q  <= SI_TX;
          end else begin
            oe_n_q <= 1'b1;
            kind_q <= (kind_q == BK_ADDR) ? BK_PTR : BK_DATA;
            sst_q  <= SI_RX;
          end
        end
        SI_TX: if (scl_fall) begin
          if (bcnt_q == 4'h7) begin
            oe_n_q <= 1'b1;
            sst_q  <= SI_RACK;
          end else begin
            tx_q   <= {tx_q[6:0], 1'b0};
            oe_n_q <= tx_q[6];
            bcnt_q <= bcnt_q + 4'h1;
          end
        end
        SI_RACK: if (scl_rise) sst_q <= sda_s_q ? SI_IDLE : SI_ACK;
      endcase
    end
  end

  // The data line is only ever pulled low
  always_ff @(posedge clk) sda_out_q <= 1'b0;

  // Register read mux
  always_comb begin
    rd_byte = 8'h00;
    unique case (ptr_q)
      `REG_STATUS: begin
        rd_byte[`STAT_IRQ_BIT] = irq_flag_q;
        rd_byte[`STAT_PWR_BIT] = pwr_flag_q;
      end
      `REG_MAIN_CFG: begin
        rd_byte[`CFG_IRQ_EN_BIT]     = irq_en_q;
        rd_byte[`CFG_MODE_LSB +: 2]  = mode_q;
        rd_byte[`CFG_TRIM_BIT]       = trim_q;
      end
      `REG_RX_SETUP: rd_byte[3:0] = rx_setup_q;
      `REG_RES_HIGH: begin
        rd_byte[5:0]          = res_vis_q[13:8];
        rd_byte[`RES_OVF_BIT] = ovf_vis_q;
      end
      `REG_RES_LOW:  rd_byte = res_vis_q[7:0];
      `REG_UP_HIGH:  rd_byte = up_hi_q;
      `REG_UP_LOW:   rd_byte = up_lo_q;
      `REG_LOW_HIGH: rd_byte = lo_hi_q;
      `REG_LOW_LOW:  rd_byte = lo_lo_q;
      `REG_PERSIST:  rd_byte[1:0] = persist_q;
      default:       rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_en_q   <= 1'(`MAIN_CFG_RST >> `CFG_IRQ_EN_BIT);
      mode_q     <= mode_t'(2'(`MAIN_CFG_RST >> `CFG_MODE_LSB));
      trim_q     <= 1'(`MAIN_CFG_RST >> `CFG_TRIM_BIT);
      rx_setup_q <= `RX_SETUP_RST;
      up_hi_q    <= `LIMIT_RST;
      up_lo_q    <= `LIMIT_RST;
      lo_hi_q    <= `LIMIT_RST;
      lo_lo_q    <= `LIMIT_RST;
      persist_q  <= `PERSIST_RST;
    end else if (wr_stb) begin
      unique case (ptr_q)
        `REG_MAIN_CFG: begin
          irq_en_q <= sh_q[`CFG_IRQ_EN_BIT];
          mode_q   <= mode_t'(sh_q[`CFG_MODE_LSB +: 2]);
          trim_q   <= sh_q[`CFG_TRIM_BIT];
        end
        `REG_RX_SETUP: rx_setup_q <= sh_q[3:0];
        `REG_UP_HIGH:  up_hi_q    <= sh_q;
        `REG_UP_LOW:   up_lo_q    <= sh_q;
        `REG_LOW_HIGH: lo_hi_q    <= sh_q;
        `REG_LOW_LOW:  lo_lo_q    <= sh_q;
        `REG_PERSIST:  persist_q  <= sh_q[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Result hand-off, held back while a read is open
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      res_vis_q  <= 14'h0000;
      ovf_vis_q  <= 1'b0;
      pend_q     <= 14'h0000;
      pend_ovf_q <= 1'b0;
      pend_v_q   <= 1'b0;
    end else if (done_p && !freeze_q) begin
      res_vis_q <= res_w_q;
      ovf_vis_q <= res_ovf_w_q;
      pend_v_q  <= 1'b0;
    end else if (done_p) begin
      pend_q     <= res_w_q;
      pend_ovf_q <= res_ovf_w_q;
      pend_v_q   <= 1'b1;
    end else if (!freeze_q && pend_v_q) begin
      res_vis_q <= pend_q;
      ovf_vis_q <= pend_ovf_q;
      pend_v_q  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Window comparison, persistence and interrupt
  // ----------------------------------------------------------------------
  wire [13:0] up_lim  = {up_hi_q[5:0], up_lo_q};
  wire [13:0] low_lim = {lo_hi_q[5:0], lo_lo_q};
  wire        trig    = (res_w_q > up_lim) || (res_w_q < low_lim);
  wire        win_evt = done_p & irq_en_q & trig
                        & ((per_cnt_q + 5'h01) >= persist_need(persist_q));
  wire        evt     = win_evt | (done_p & irq_en_q & res_ovf_w_q);
  // Set wins over a status read landing in the same cycle
  wire        irq_d   = irq_en_q & (evt | (irq_flag_q & ~stat_rd));
  wire        pwr_d   = pwr_flag_q & ~stat_rd;

  // One step per out-of-window conversion, saturating at the largest need
  always_ff @(posedge clk) begin
    if (!resetn || !irq_en_q) per_cnt_q <= 5'h00;
    else if (done_p) begin
      if (!trig) per_cnt_q <= 5'h00;
      else if (per_cnt_q != 5'h10) per_cnt_q <= per_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_flag_q <= 1'b0;
      pwr_flag_q <= 1'b1;
      int_n_q    <= 1'b0;
    end else begin
      irq_flag_q <= irq_d;
      pwr_flag_q <= pwr_d;
      int_n_q    <= ~(irq_d | pwr_d);
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign sda_out        = sda_out_q;
  assign sda_oe_n       = oe_n_q;
  assign int_n          = int_n_q;
  assign dac_code       = dac_q;
  assign chan_ir        = chan_ir_q;
  assign analog_on      = analog_on_q;
  assign light_gain_sel = rx_setup_q[`RX_GAIN_LSB +: 2];
  assign trim_factory   = trim_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_SHUTDOWN_OFF: assert property (@(posedge conv_clk) disable iff (!crst_n_q)
    (cfg_sync_q[3:2] == 2'b00) |=> !analog_on_q) else $error("front end on in shutdown");
  AST_MSB_FIRST: assert property (@(posedge conv_clk) disable iff (!crst_n_q)
    (cst_q == CV_INTEG && cnt_q == CW'(1) && cfg_sync_q[3:2] != 2'b00)
    |=> dac_q == full_code(ct_q) - (full_code(ct_q) >> 1)) else $error("first trial not MSB");
  AST_IRQ_OFF: assert property (@(posedge clk) disable iff (!resetn)
    !irq_en_q |=> !irq_flag_q) else $error("flag set while disabled");
  AST_EVENT_PIN: assert property (@(posedge clk) disable iff (!resetn)
    (irq_en_q && evt) |=> irq_flag_q && !int_n) else $error("event missed");
  AST_OVF_IRQ: assert property (@(posedge clk) disable iff (!resetn)
    (done_p && res_ovf_w_q && irq_en_q) |=> irq_flag_q && !int_n) else $error("overflow no irq");
  AST_FROZEN: assert property (@(posedge clk) disable iff (!resetn)
    (freeze_q && !stop_c) |=> $stable(res_vis_q) && $stable(ovf_vis_q))
    else $error("result changed during read");
  AST_STATUS_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
    (stat_rd && !evt) |=> !irq_flag_q && !pwr_flag_q && int_n) else $error("status read kept flag");
  AST_PERSIST_RESET: assert property (@(posedge clk) disable iff (!resetn)
    (done_p && !trig) |=> per_cnt_q == 5'h00) else $error("persist count not reset");
  AST_SETUP_RESET: assert property (@(posedge clk)
    !resetn |=> rx_setup_q == 4'h0 && up_hi_q == 8'h00) else $error("setup not reset");

endmodule // ambient_light_readout_control

// [testbench/i2c_host.sv]
// Serial host model that configures the sensor and reads its results
`timescale 1ns/100ps
module i2c_host (
  // Clock and bus lines
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  logic [8:0] rx;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Phases of 8 clk, twice the slave's minimum
  task automatic st(input logic c, input logic d);
    repeat (8) @(posedge clk);
    scl <= c;
    sda_drv <= d;
  endtask
  task automatic sr();
    st(1'b1, 1'b1);
    st(1'b1, 1'b0);
    st(1'b0, 1'b0);
  endtask
  task automatic sp();
    st(1'b0, 1'b0);
    st(1'b1, 1'b0);
    st(1'b1, 1'b1);
  endtask
  // Data changes only while the clock is low; sampled at end of high
  task automatic xb(input logic [8:0] o);
    for (int k = 8; k >= 0; k--) begin
      st(1'b0, o[k]);
      st(1'b1, o[k]);
      repeat (8) @(posedge clk);
      rx[k] = sda;
      scl <= 1'b0;
    end
  endtask
  task automatic hdr(input logic [7:0] a);
    sr();
    xb({8'h80, 1'b1});
    xb({a, 1'b1});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    hdr(a);
    xb({d, 1'b1});
    sp();
  endtask
  // Two bytes in one transaction so the pair cannot tear
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    hdr(a);
    sr();
    xb({8'h81, 1'b1});
    xb({8'hff, 1'b0});
    v[15:8] = rx[8:1];
    xb({8'hff, 1'b1});
    v[7:0] = rx[8:1];
    sp();
  endtask
endmodule // i2c_host

// [testbench/ambient_light_readout_control_tb.sv]
// Self-checking bench of the ambient light readout
`timescale 1ns/100ps
module ambient_light_readout_control_tb;
  logic        clk, conv_clk, resetn, comp_in, scl, sda_drv;
  logic        sda_out, sda_oe_n, int_n, chan_ir, analog_on, trim_factory;
  logic [13:0] dac_code, lvl_g, lvl_i;
  logic [1:0]  light_gain_sel;
  logic [15:0] v;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  wire         sda = sda_drv & (sda_oe_n | sda_out);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    conv_clk = 1'b0;
    #17;
    forever #40 conv_clk = ~conv_clk;
  end
  // Comparator: high while the light level reaches the trial code
  always @(posedge conv_clk) comp_in <= ((chan_ir ? lvl_i : lvl_g) >= dac_code);
  ambient_light_readout_control #(.INTEG_CYC(64)) DUT (
    .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .int_n(int_n), .conv_clk(conv_clk), .comp_in(comp_in),
    .dac_code(dac_code), .chan_ir(chan_ir), .analog_on(analog_on),
    .light_gain_sel(light_gain_sel), .trim_factory(trim_factory));
  i2c_host host (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Enough time for two full conversions in any mode
  task automatic settle();
    repeat (5000) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("int_n", int_n, 16'h0);
    host.rd(8'h00, v);
    chk("status", v, 16'h0424);
    chk("int_n", int_n, 16'h1);
    host.rd(8'h00, v);
    chk("status", v, 16'h0024);
    host.rd(8'h02, v);
    chk("rx_setup", v, 16'h0000);
    host.rd(8'h06, v);
    chk("upper", v, 16'h0000);
    host.rd(8'h08, v);
    chk("lower", v, 16'h0000);
    host.wr(8'h02, 8'h03);
    chk("gain", light_gain_sel, 16'h3);
    host.rd(8'h02, v);
    chk("rx_setup", v, 16'h0300);
    host.wr(8'h02, 8'h00);
  endtask
  task automatic t_modes();
    logic [7:0]  cfg [3] = '{8'h24, 8'h28, 8'h2c};
    logic [15:0] exp [3] = '{16'd2000, 16'd3000, 16'd1000};
    for (int m = 0; m < 3; m++) begin
      host.wr(8'h01, cfg[m]);
      settle();
      host.rd(8'h04, v);
      chk("result", v, exp[m]);
    end
    host.wr(8'h01, 8'h20);
    repeat (100) @(posedge clk);
    chk("analog_on", analog_on, 16'h0);
    chk("trim", trim_factory, 16'h1);
    host.rd(8'h04, v);
    chk("held", v, 16'd1000);
  endtask
  // Upper limit high byte 0xc0 means a limit of zero once top bits drop
  task automatic t_irq();
    host.wr(8'h06, 8'hc0);
    host.wr(8'h01, 8'h28);
    settle();
    chk("int_n", int_n, 16'h1);
    host.wr(8'h01, 8'h29);
    settle();
    chk("int_n", int_n, 16'h0);
    host.rd(8'h00, v);
    chk("status", v, 16'h0129);
    host.wr(8'h01, 8'h28);
    chk("int_n", int_n, 16'h1);
  endtask
  task automatic t_ovf();
    lvl_g <= 14'h3fff;
    host.wr(8'h06, 8'h3f);
    host.wr(8'h07, 8'hff);
    host.rd(8'h06, v);
    chk("upper", v, 16'h3fff);
    settle();
    host.rd(8'h04, v);
    chk("result", v, 16'h7fff);
    host.wr(8'h01, 8'h29);
    settle();
    chk("int_n", int_n, 16'h0);
    host.wr(8'h02, 8'h01);
    chk("gain", light_gain_sel, 16'h1);
  endtask
  // Shortest integration gives 8 result bits; a full 8-bit code is overflow
  task automatic t_res();
    host.wr(8'h01, 8'h28);
    host.wr(8'h02, 8'h0c);
    lvl_g <= 14'd200;
    settle();
    host.rd(8'h04, v);
    chk("result8", v, 16'h00c8);
    lvl_g <= 14'd3000;
    repeat (1500) @(posedge clk);
    host.rd(8'h04, v);
    chk("result8", v, 16'h40ff);
  endtask
  // Lower limit above the reading triggers every cycle; sixteen are needed
  task automatic t_persist();
    lvl_g <= 14'd200;
    host.wr(8'h0a, 8'h03);
    host.wr(8'h08, 8'h3f);
    host.wr(8'h01, 8'h29);
    repeat (1500) @(posedge clk);
    chk("int_n", int_n, 16'h1);
    repeat (5000) @(posedge clk);
    chk("int_n", int_n, 16'h0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // Reset spans several slow-clock edges so the conversion side clears too
  initial begin
    resetn = 1'b0;
    lvl_g = 14'd3000;
    lvl_i = 14'd1000;
    repeat (40) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_modes();
    t_irq();
    t_ovf();
    t_res();
    t_persist();
    tally_and_finish();
  end
endmodule // ambient_light_readout_control_tb
